// *** rtl/drive_sup_pkg.sv ***
// Shared constants, types and arithmetic for the drive supervisor
package drive_sup_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned STOP_UNIT_NS = 1000000;
  localparam int unsigned STOP_UNIT_CYCLES = STOP_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Enable source selection
  // ----------------------------------------------------------------
  localparam logic [1:0] EN_SRC_DIN = 2'h0;
  localparam logic [1:0] EN_SRC_SERIAL = 2'h1;
  localparam logic [1:0] EN_SRC_CAN = 2'h2;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned VAL_W = 16;
  localparam int unsigned POS_W = 32;
  localparam logic [15:0] RATE_FREE = 16'hffff;
  localparam logic [15:0] SPEED_RST = 16'h0000;

  typedef logic signed [VAL_W-1:0] speed_type;
  typedef logic [VAL_W-1:0] rate_type;
  typedef logic signed [POS_W-1:0] pos_type;

  typedef struct packed {
    logic [1:0] enable_src;
    logic limit_nc;
    logic inhibit_perm;
    logic reverse;
    logic jog_mode;
  } cfg_type;

  typedef struct packed {
    rate_type quick;
    rate_type limit;
    rate_type stop;
  } decel_type;

  typedef struct packed {
    rate_type speed_limit;
    rate_type current_limit;
    pos_type pos_min;
    pos_type pos_max;
  } limits_type;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  function automatic speed_type clamp_mag(speed_type v, rate_type lim);
    logic signed [17:0] wide;
    logic signed [17:0] top;
    wide = 18'(v);
    top = 18'({2'b00, lim});
    if (wide > top)
      wide = top;
    else if (wide < -top)
      wide = -top;
    return speed_type'(wide[15:0]);
  endfunction

  function automatic speed_type step_toward(speed_type cur, speed_type tgt,
                                            rate_type rate);
    logic signed [17:0] nxt;
    logic signed [17:0] r;
    nxt = 18'(cur);
    r = 18'({2'b00, rate});
    if (cur > tgt)
    begin
      nxt = nxt - r;
      if (nxt < 18'(tgt))
        nxt = 18'(tgt);
    end
    else if (cur < tgt)
    begin
      nxt = nxt + r;
      if (nxt > 18'(tgt))
        nxt = 18'(tgt);
    end
    return speed_type'(nxt[15:0]);
  endfunction

endpackage

// *** rtl/limit_guard.sv ***
// Limit switch polarity, direction blocking and permanent inhibit
`timescale 1ns/100ps
`default_nettype none
module limit_guard
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic limit_input_first_i,
  input wire logic limit_input_second_i,
  input wire logic limit_nc_i,
  input wire logic inhibit_perm_i,
  input wire logic ctrl_enabled_i,
  output logic block_pos_o,
  output logic block_neg_o
);
  import drive_sup_pkg::*;

  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] latch_q;
  logic [1:0] latch_d;
  logic [1:0] block_q;
  logic [1:0] block_d;
  logic [1:0] active;
  logic [1:0] warm_q;

  // ----------------------------------------------------------------
  // Polarity and latch
  // ----------------------------------------------------------------
  always_comb
  begin
    // Limits masked until the synchroniser holds real pin levels
    active = warm_q[1] ? (limit_nc_i ? ~sync_q : sync_q) : 2'h0; // RULE11
    latch_d = latch_q | (active & {2{inhibit_perm_i}}); // RULE13
    if (!ctrl_enabled_i)
      latch_d = 2'h0; // RULE15
    block_d = active | latch_q; // RULE12 RULE14
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      warm_q <= 2'h0;
      latch_q <= 2'h0;
      block_q <= 2'h0;
    end
    else
    begin
      meta_q <= {limit_input_second_i, limit_input_first_i};
      warm_q <= {warm_q[0], 1'b1};
      sync_q <= meta_q;
      latch_q <= latch_d;
      block_q <= block_d;
    end
  end

  assign block_pos_o = block_q[0];
  assign block_neg_o = block_q[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  latch_clear_a: assert property (@(posedge sys_clk_i) // RULE15
    disable iff (!rst_n_i) !ctrl_enabled_i |=> latch_q == 2'h0)
    else $error("inhibit latch survived disable");
  latch_hold_a: assert property (@(posedge sys_clk_i) // RULE13
    disable iff (!rst_n_i)
    (ctrl_enabled_i && inhibit_perm_i && active[0]) ##1 ctrl_enabled_i
    |=> block_q[0])
    else $error("positive inhibit not held");
  polarity_a: assert property (@(posedge sys_clk_i) // RULE11
    disable iff (!rst_n_i)
    (warm_q[1] && limit_nc_i && !sync_q[1]) |=> block_q[1])
    else $error("open contact did not block");

endmodule // limit_guard
`default_nettype wire

// *** rtl/stop_timer.sv ***
// Maximum stop delay timer counted in milliseconds
`timescale 1ns/100ps
`default_nettype none
module stop_timer
#(
  parameter int unsigned TICK_CYCLES = drive_sup_pkg::STOP_UNIT_CYCLES
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [15:0] delay_ms_i,
  output logic expired_o
);
  import drive_sup_pkg::*;

  logic [31:0] tick_q;
  logic [31:0] tick_d;
  logic [15:0] ms_q;
  logic [15:0] ms_d;
  logic exp_q;
  logic exp_d;

  always_comb
  begin
    tick_d = 32'h0;
    ms_d = 16'h0;
    exp_d = 1'b0;
    if (run_i)
    begin
      tick_d = tick_q + 32'h1;
      ms_d = ms_q;
      if (tick_q == 32'(TICK_CYCLES - 1))
      begin
        tick_d = 32'h0;
        if (ms_q != 16'hffff)
          ms_d = ms_q + 16'h1;
      end
      exp_d = (ms_q >= delay_ms_i); // RULE4
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_q <= 32'h0;
      ms_q <= 16'h0;
      exp_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_d;
      ms_q <= ms_d;
      exp_q <= exp_d;
    end
  end

  assign expired_o = exp_q;

  no_early_a: assert property (@(posedge sys_clk_i) // RULE4
    disable iff (!rst_n_i) !run_i |=> !expired_o)
    else $error("delay expired while idle");

endmodule // stop_timer
`default_nettype wire

// *** rtl/drive_enable_supervisor.sv ***
// Drive enable, stop deceleration and setpoint limiting supervisor
//
// Behaviour
// RULE1: Enable loss or error stops with quick-stop rate
// RULE2: Active limit switch stops with limit rate
// RULE3: Jog mode, stop input low uses stop rate
// RULE4: Stop delay exceeded switches stage off, coast
// RULE5: Speed setpoint magnitude clamped to speed limit
// RULE6: Commanded current clamped to maximum current
// RULE7: Position range acts as software limit switches
// RULE8: First source: enable from enable input only
// RULE9: Second source: enable input plus serial command
// RULE10: Third source: enable input plus CAN command
// RULE11: Limit input polarity selects NC or NO
// RULE12: Active limit blocks its direction only
// RULE13: Permanent option latches blocked direction
// RULE14: Latched direction still allows moving away
// RULE15: Latched inhibit clears only on disable
// RULE16: Reversal inverts counting, speed and current signs
// RULE17: Losing any enable condition starts quick stop
`timescale 1ns/100ps
`default_nettype none
module drive_enable_supervisor
#(
  parameter int unsigned TICK_CYCLES = drive_sup_pkg::STOP_UNIT_CYCLES
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_input_i,
  input wire logic stop_input_i,
  input wire logic limit_input_first_i,
  input wire logic limit_input_second_i,
  input wire logic serial_enable_cmd_i,
  input wire logic can_enable_cmd_i,
  input wire logic error_i,
  input wire drive_sup_pkg::cfg_type cfg_i,
  input wire drive_sup_pkg::decel_type decel_i,
  input wire drive_sup_pkg::limits_type limits_i,
  input wire logic [15:0] max_stop_delay_ms_i,
  input wire drive_sup_pkg::speed_type speed_set_i,
  input wire drive_sup_pkg::speed_type current_set_i,
  input wire drive_sup_pkg::pos_type position_raw_i,
  output logic stage_enable_o,
  output logic ctrl_enabled_o,
  output logic coasting_o,
  output logic block_pos_o,
  output logic block_neg_o,
  output drive_sup_pkg::speed_type speed_cmd_o,
  output drive_sup_pkg::speed_type current_cmd_o,
  output drive_sup_pkg::pos_type position_o
);
  import drive_sup_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_QSTOP, ST_COAST} state_type;

  state_type state_q;
  state_type state_d;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic en_pin;
  logic stop_pin;
  logic enable_ok;
  logic sw_block_pos;
  logic sw_block_neg;
  logic blk_pos;
  logic blk_neg;
  logic hw_block_pos;
  logic hw_block_neg;
  logic expired;
  speed_type tgt;
  speed_type clamped;
  rate_type rate;
  pos_type pos_count;
  speed_type speed_q;
  speed_type speed_d;
  speed_type speed_out_q;
  speed_type speed_out_d;
  speed_type current_q;
  speed_type current_d;
  pos_type position_q;
  pos_type position_d;
  logic stage_q;
  logic stage_d;
  logic ctrl_en_q;
  logic ctrl_en_d;
  logic coast_q;
  logic coast_d;
  logic blk_pos_q;
  logic blk_neg_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
    end
    else
    begin
      meta_q <= {stop_input_i, enable_input_i};
      sync_q <= meta_q;
    end
  end

  assign en_pin = sync_q[0];
  assign stop_pin = sync_q[1];

  // ----------------------------------------------------------------
  // Enable logic
  // ----------------------------------------------------------------
  always_comb
  begin
    case (cfg_i.enable_src)
      EN_SRC_DIN: enable_ok = en_pin; // RULE8
      EN_SRC_SERIAL: enable_ok = en_pin & serial_enable_cmd_i; // RULE9
      EN_SRC_CAN: enable_ok = en_pin & can_enable_cmd_i; // RULE10
      default: enable_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Limit switches and position range
  // ----------------------------------------------------------------
  limit_guard u_limit_guard
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .limit_input_first_i(limit_input_first_i),
    .limit_input_second_i(limit_input_second_i),
    .limit_nc_i(cfg_i.limit_nc),
    .inhibit_perm_i(cfg_i.inhibit_perm),
    .ctrl_enabled_i(ctrl_en_q),
    .block_pos_o(hw_block_pos),
    .block_neg_o(hw_block_neg)
  );

  always_comb
  begin
    pos_count = cfg_i.reverse ? -position_raw_i : position_raw_i; // RULE16
    sw_block_pos = (pos_count >= limits_i.pos_max); // RULE7
    sw_block_neg = (pos_count <= limits_i.pos_min); // RULE7
    blk_pos = hw_block_pos | sw_block_pos;
    blk_neg = hw_block_neg | sw_block_neg;
  end

  // ----------------------------------------------------------------
  // Stop delay
  // ----------------------------------------------------------------
  stop_timer #(.TICK_CYCLES(TICK_CYCLES)) u_stop_timer
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state_q == ST_QSTOP),
    .delay_ms_i(max_stop_delay_ms_i),
    .expired_o(expired)
  );

  // ----------------------------------------------------------------
  // Sequence and setpoint path
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    clamped = clamp_mag(speed_set_i, limits_i.speed_limit); // RULE5
    tgt = clamped;
    rate = RATE_FREE;
    if (cfg_i.jog_mode && !stop_pin)
    begin
      tgt = speed_type'(SPEED_RST);
      rate = decel_i.stop; // RULE3
    end
    else if ((clamped > 0 && blk_pos) || (clamped < 0 && blk_neg))
    begin
      tgt = speed_type'(SPEED_RST); // RULE12 RULE14
      rate = decel_i.limit; // RULE2
    end
    case (state_q)
      ST_OFF:
        if (enable_ok && !error_i)
          state_d = ST_RUN;
      ST_RUN:
        if (!enable_ok || error_i)
          state_d = ST_QSTOP; // RULE1 RULE17
      ST_QSTOP:
        if (speed_q == speed_type'(SPEED_RST))
          state_d = ST_OFF;
        else if (expired)
          state_d = ST_COAST; // RULE4
      ST_COAST:
        if (!enable_ok && !error_i)
          state_d = ST_OFF;
      default: state_d = ST_OFF;
    endcase
    case (state_d)
      ST_RUN: speed_d = step_toward(speed_q, tgt, rate);
      ST_QSTOP: speed_d = step_toward(speed_q, speed_type'(SPEED_RST),
                                      decel_i.quick); // RULE1
      default: speed_d = speed_type'(SPEED_RST);
    endcase
    stage_d = (state_d == ST_RUN) || (state_d == ST_QSTOP); // RULE4
    ctrl_en_d = (state_d == ST_RUN);
    coast_d = (state_d == ST_COAST);
    current_d = stage_d ? clamp_mag(current_set_i, limits_i.current_limit)
                        : speed_type'(SPEED_RST); // RULE6
    speed_out_d = cfg_i.reverse ? -speed_d : speed_d; // RULE16
    if (cfg_i.reverse)
      current_d = -current_d; // RULE16
    position_d = pos_count;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_OFF;
      speed_q <= '0;
      speed_out_q <= '0;
      current_q <= '0;
      position_q <= '0;
      stage_q <= 1'b0;
      ctrl_en_q <= 1'b0;
      coast_q <= 1'b0;
      blk_pos_q <= 1'b0;
      blk_neg_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      speed_q <= speed_d;
      speed_out_q <= speed_out_d;
      current_q <= current_d;
      position_q <= position_d;
      stage_q <= stage_d;
      ctrl_en_q <= ctrl_en_d;
      coast_q <= coast_d;
      blk_pos_q <= blk_pos;
      blk_neg_q <= blk_neg;
    end
  end

  assign stage_enable_o = stage_q;
  assign ctrl_enabled_o = ctrl_en_q;
  assign coasting_o = coast_q;
  assign block_pos_o = blk_pos_q;
  assign block_neg_o = blk_neg_q;
  assign speed_cmd_o = speed_out_q;
  assign current_cmd_o = current_q;
  assign position_o = position_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  qstop_entry_a: assert property ( // RULE1
    (state_q == ST_RUN && error_i) |=> state_q == ST_QSTOP && stage_q)
    else $error("error did not start quick stop");
  qstop_rate_a: assert property ( // RULE1
    (state_q == ST_QSTOP && state_d == ST_QSTOP && speed_q > 0
     && 17'(speed_q) > 17'({1'b0, decel_i.quick}) && $stable(decel_i))
    |=> 17'(speed_q) == 17'($past(speed_q)) - 17'({1'b0, decel_i.quick}))
    else $error("quick stop rate wrong");
  coast_a: assert property ( // RULE4
    (state_q == ST_QSTOP && expired && speed_q != 0)
    |=> !stage_enable_o && coasting_o)
    else $error("stage not off after stop delay");
  speed_clamp_a: assert property ( // RULE5
    (clamped >= 0 && 17'(clamped) <= 17'({1'b0, limits_i.speed_limit}))
    || (clamped < 0 && 17'(-18'(clamped)) <= 17'({1'b0, limits_i.speed_limit})))
    else $error("speed target above limit");
  din_enable_a: assert property ( // RULE8
    (cfg_i.enable_src == EN_SRC_DIN && en_pin && !error_i
     && state_q == ST_OFF) |=> ctrl_enabled_o ##0 stage_enable_o)
    else $error("digital input did not enable");
  serial_loss_a: assert property ( // RULE9 RULE17
    (cfg_i.enable_src == EN_SRC_SERIAL && !serial_enable_cmd_i
     && state_q == ST_RUN) |=> !ctrl_enabled_o)
    else $error("serial command loss ignored");
  can_loss_a: assert property ( // RULE10
    (cfg_i.enable_src == EN_SRC_CAN && !can_enable_cmd_i
     && state_q == ST_RUN) |=> !ctrl_enabled_o)
    else $error("CAN command loss ignored");
  limit_block_a: assert property ( // RULE12
    (state_q == ST_RUN && state_d == ST_RUN && blk_pos && !blk_neg)
    |=> speed_q <= $past(speed_q) || speed_q <= 0)
    else $error("blocked direction accelerated");
  reverse_a: assert property ( // RULE16
    cfg_i.reverse |=> speed_cmd_o == -$past(speed_d))
    else $error("reversal sign wrong");

  run_c: cover property (state_q == ST_RUN ##1 state_q == ST_QSTOP);
  coast_c: cover property (state_q == ST_QSTOP ##1 state_q == ST_COAST);
  limit_c: cover property (state_q == ST_RUN && blk_pos && clamped > 0);

endmodule // drive_enable_supervisor
`default_nettype wire

// *** sim/far_side_model.sv ***
// Far side model: limit switches, enabling host and power stage
`timescale 1ns/100ps
`default_nettype none
module far_side_model
(
  input wire logic sys_clk_i,
  input wire logic [1:0] enable_src_i,
  input wire logic host_en_i,
  input wire logic limit_nc_i,
  input wire logic sw_first_i,
  input wire logic sw_second_i,
  input wire logic stage_enable_i,
  input wire drive_sup_pkg::speed_type speed_cmd_i,
  input wire logic pos_load_i,
  input wire drive_sup_pkg::pos_type pos_val_i,
  output logic serial_enable_cmd_o,
  output logic can_enable_cmd_o,
  output logic limit_input_first_o,
  output logic limit_input_second_o,
  output drive_sup_pkg::pos_type position_raw_o
);
  import drive_sup_pkg::*;

  // Host issues the enable command over the selected link
  assign serial_enable_cmd_o = host_en_i && enable_src_i == EN_SRC_SERIAL;
  assign can_enable_cmd_o = host_en_i && enable_src_i == EN_SRC_CAN;

  // Switch contact wiring: NC opens (low) when hit, NO closes (high)
  assign limit_input_first_o = limit_nc_i ? ~sw_first_i : sw_first_i;
  assign limit_input_second_o = limit_nc_i ? ~sw_second_i : sw_second_i;

  // Power stage moves the axis while it is on
  always_ff @(posedge sys_clk_i)
  begin
    if (pos_load_i)
      position_raw_o <= pos_val_i;
    else if (stage_enable_i)
      position_raw_o <= position_raw_o + pos_type'(speed_cmd_i);
  end
endmodule // far_side_model
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking testbench for the drive enable supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import drive_sup_pkg::*;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic en_pin, stop_pin, host_en, sw_first, sw_second, err, pos_load;
  logic ser_cmd, can_cmd, lim_first, lim_second;
  logic stage_enable_o, ctrl_enabled_o, coasting_o, block_pos_o, block_neg_o;
  cfg_type cfg;
  decel_type decel;
  limits_type lim;
  logic [15:0] max_delay;
  speed_type speed_set, current_set, speed_cmd_o, current_cmd_o;
  pos_type pos_val, pos_raw, position_o;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int k;

  always #25 sys_clk = ~sys_clk;

  drive_enable_supervisor #(.TICK_CYCLES(4)) i_drive_enable_supervisor (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .enable_input_i(en_pin),
    .stop_input_i(stop_pin), .limit_input_first_i(lim_first),
    .limit_input_second_i(lim_second), .serial_enable_cmd_i(ser_cmd),
    .can_enable_cmd_i(can_cmd), .error_i(err), .cfg_i(cfg),
    .decel_i(decel), .limits_i(lim), .max_stop_delay_ms_i(max_delay),
    .speed_set_i(speed_set), .current_set_i(current_set),
    .position_raw_i(pos_raw), .stage_enable_o(stage_enable_o),
    .ctrl_enabled_o(ctrl_enabled_o), .coasting_o(coasting_o),
    .block_pos_o(block_pos_o), .block_neg_o(block_neg_o),
    .speed_cmd_o(speed_cmd_o), .current_cmd_o(current_cmd_o),
    .position_o(position_o));

  far_side_model i_far_side_model (
    .sys_clk_i(sys_clk), .enable_src_i(cfg.enable_src), .host_en_i(host_en),
    .limit_nc_i(cfg.limit_nc), .sw_first_i(sw_first),
    .sw_second_i(sw_second), .stage_enable_i(stage_enable_o),
    .speed_cmd_i(speed_cmd_o), .pos_load_i(pos_load), .pos_val_i(pos_val),
    .serial_enable_cmd_o(ser_cmd), .can_enable_cmd_o(can_cmd),
    .limit_input_first_o(lim_first), .limit_input_second_o(lim_second),
    .position_raw_o(pos_raw));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wait_en(input logic v);
    int w;
    w = 0;
    while (ctrl_enabled_o !== v && w < 20)
    begin
      cyc(1);
      w++;
    end
    chk(ctrl_enabled_o, v);
  endtask

  task automatic wait_zero;
    int w;
    w = 0;
    while (speed_cmd_o !== 16'sh0000 && w < 300)
    begin
      cyc(1);
      w++;
    end
    chk(speed_cmd_o, 0);
  endtask

  task automatic ramp_chk(input int r);
    int s;
    s = speed_cmd_o;
    cyc(1);
    chk(s - speed_cmd_o, r);
  endtask

  task automatic go(input int sp);
    speed_set = 16'(sp);
    en_pin = 1'b1;
    host_en = 1'b1;
    wait_en(1'b1);
  endtask

  task automatic halt;
    en_pin = 1'b0;
    wait_en(1'b0);
    wait_zero;
    cyc(3);
    chk(stage_enable_o, 1'b0);
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop;
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {en_pin, host_en, sw_first, sw_second, err} = '0;
    stop_pin = 1'b1;
    pos_load = 1'b1;
    pos_val = '0;
    cfg = '0;
    cfg.limit_nc = 1'b1;
    decel = '{quick: 16'h0064, limit: 16'h0032, stop: 16'h0014};
    lim = '{speed_limit: 16'h07d0, current_limit: 16'h03e8,
            pos_min: -32'sh1000_0000, pos_max: 32'sh1000_0000};
    max_delay = 16'h0064;
    speed_set = '0;
    current_set = 16'sh7530;
    cyc(4);
    chk({stage_enable_o, ctrl_enabled_o, speed_cmd_o}, '0);
    rst_n = 1'b1;
    pos_load = 1'b0;
    go(3000);
    chk(stage_enable_o, 1'b1);
    chk(speed_cmd_o, 2000);
    chk(current_cmd_o, 1000);
    current_set = -16'sh7530;
    cyc(2);
    chk(current_cmd_o, -1000);
    en_pin = 1'b0;
    wait_en(1'b0);
    ramp_chk(100);
    halt;
    for (int s = 1; s < 4; s++)
    begin
      cfg.enable_src = 2'(s);
      host_en = 1'b0;
      en_pin = 1'b1;
      cyc(8);
      chk(ctrl_enabled_o, 1'b0);
      host_en = 1'b1;
      cyc(8);
      chk(ctrl_enabled_o, s < 3);
      host_en = 1'b0;
      wait_en(1'b0);
      halt;
    end
    cfg.enable_src = EN_SRC_DIN;
    go(1000);
    err = 1'b1;
    wait_en(1'b0);
    ramp_chk(100);
    wait_zero;
    halt;
    err = 1'b0;
    decel.quick = 16'h0001;
    max_delay = 16'h0002;
    go(3000);
    en_pin = 1'b0;
    k = 0;
    while (coasting_o !== 1'b1 && k < 40)
    begin
      cyc(1);
      k++;
    end
    chk(coasting_o, 1'b1);
    chk({stage_enable_o, speed_cmd_o}, '0);
    chk(k >= 9 && k <= 16, 1'b1);
    decel.quick = 16'h0064;
    max_delay = 16'h0064;
    cyc(6);
    for (int nc = 1; nc >= 0; nc--)
    begin
      cfg.limit_nc = nc[0];
      go(500);
      sw_first = 1'b1;
      cyc(6);
      chk({block_pos_o, block_neg_o}, 2'b10);
      ramp_chk(50);
      wait_zero;
      speed_set = -16'sd500;
      cyc(4);
      chk(speed_cmd_o, -500);
      sw_first = 1'b0;
      sw_second = 1'b1;
      cyc(6);
      chk({block_pos_o, block_neg_o}, 2'b01);
      wait_zero;
      speed_set = 16'sd500;
      cyc(4);
      chk(speed_cmd_o, 500);
      sw_second = 1'b0;
      halt;
    end
    cfg.inhibit_perm = 1'b1;
    go(-300);
    sw_second = 1'b1;
    cyc(6);
    sw_second = 1'b0;
    cyc(8);
    chk(block_neg_o, 1'b1);
    chk(speed_cmd_o, 0);
    speed_set = 16'sd300;
    cyc(4);
    chk(speed_cmd_o, 300);
    halt;
    chk(block_neg_o, 1'b0);
    cfg.inhibit_perm = 1'b0;
    cfg.jog_mode = 1'b1;
    go(400);
    stop_pin = 1'b0;
    cyc(4);
    ramp_chk(20);
    wait_zero;
    chk(ctrl_enabled_o, 1'b1);
    stop_pin = 1'b1;
    cfg.jog_mode = 1'b0;
    halt;
    pos_load = 1'b1;
    pos_val = 32'sh1000_0000;
    cyc(6);
    chk({block_pos_o, block_neg_o}, 2'b10);
    pos_val = -32'sh1000_0000;
    cyc(6);
    chk({block_pos_o, block_neg_o}, 2'b01);
    cfg.reverse = 1'b1;
    pos_val = 32'sh0000_0064;
    cyc(4);
    chk(position_o, -100);
    pos_load = 1'b0;
    current_set = 16'sh0032;
    go(200);
    cyc(2);
    chk(speed_cmd_o, -200);
    chk(current_cmd_o, -50);
    halt;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
